// ==== adc_cfg_port.sv ====
// serial configuration port and mode-control register bank of a dual converter
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_port
    import adc_cfg_pkg::*;
#(
    parameter int CHANNELS = 2
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic interface_select,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic [CHANNELS-1:0][13:0] sample,
    input wire logic [CHANNELS-1:0] overrange_flag,
    input wire logic sample_valid,
    output logic [CHANNELS-1:0][13:0] data_out,
    output logic [CHANNELS-1:0] overrange_out,
    output logic data_oe,
    output logic sleep_en,
    output logic nap_en,
    output logic second_channel_powerdown,
    output logic out_clock_invert,
    output logic out_clock_delay_hi,
    output logic out_clock_delay_lo,
    output logic duty_cycle_stabilizer_en,
    output logic drive_current_sel_2,
    output logic drive_current_sel_1,
    output logic drive_current_sel_0,
    output logic [5:0] drive_current_qma,
    output logic internal_termination_en,
    output logic pattern_enable,
    output logic scramble_en,
    output logic odd_bit_invert_en,
    output logic signed_format_en
);
    cfg_state_t q, n;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_stb;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic frame_active;
    logic [CHANNELS-1:0] ch_oe;
    logic [5:0] base_qma;

    adc_cfg_shifter u_shift (
        .clock(clock),
        .nrst(nrst),
        .interface_select(interface_select),
        .cs_n(cs_n),
        .sck(sck),
        .sdi(sdi),
        .rd_data(rd_data),
        .rd_addr(rd_addr),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .frame_active(frame_active),
        .sdo_oe(sdo_oe)
    );

    // the line is only ever pulled low
    assign sdo_out = 1'b0;

    always_comb
    begin
        n = q;
        if (wr_stb)
        begin
            case (wr_addr)
                `ADDR_RESET:
                begin
                    if (wr_data[`RESET_BIT])
                        n = '0;
                end
                // unused bits kept at zero; bit 0 cleared only in the power-down register
                `ADDR_PD: n.pd = wr_data & `PD_MASK;
                `ADDR_TIM: n.tim = wr_data & `TIM_MASK;
                `ADDR_DRV: n.drv = wr_data & `DRV_MASK;
                `ADDR_FMT: n.fmt = wr_data & `FMT_MASK;
                default: n = q;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= n;
    end

    // reset register reads as zero, unmapped too
    always_comb
    begin
        case (rd_addr)
            `ADDR_PD: rd_data = q.pd;
            `ADDR_TIM: rd_data = q.tim;
            `ADDR_DRV: rd_data = q.drv;
            `ADDR_FMT: rd_data = q.fmt;
            default: rd_data = `REG_RESET;
        endcase
    end

    // drive current in quarter milliamps; unused code falls back to default
    always_comb
    begin
        case (q.drv[4:2])
            3'h1: base_qma = 6'h10;
            3'h2: base_qma = 6'h12;
            3'h4: base_qma = 6'h0C;
            3'h5: base_qma = 6'h0A;
            3'h7: base_qma = 6'h07;
            default: base_qma = 6'h0E;
        endcase
    end

    assign drive_current_qma = q.drv[1] ? {base_qma[4:0], 1'b0} : base_qma;

    assign sleep_en = q.pd[3];
    assign nap_en = q.pd[2];
    assign second_channel_powerdown = q.pd[1];
    assign out_clock_invert = q.tim[3];
    assign out_clock_delay_hi = q.tim[2];
    assign out_clock_delay_lo = q.tim[1];
    assign duty_cycle_stabilizer_en = q.tim[0];
    assign drive_current_sel_2 = q.drv[4];
    assign drive_current_sel_1 = q.drv[3];
    assign drive_current_sel_0 = q.drv[2];
    assign internal_termination_en = q.drv[1];
    assign pattern_enable = q.fmt[2];
    assign scramble_en = q.fmt[1];
    assign odd_bit_invert_en = q.fmt[4];
    assign signed_format_en = q.fmt[0];

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_ch
            adc_cfg_formatter u_fmt (
                .clock(clock),
                .nrst(nrst),
                .sample(sample[ch]),
                .overrange_flag(overrange_flag[ch]),
                .sample_valid(sample_valid),
                .fmt_reg(q.fmt),
                .outputs_high_z(q.drv[0]),
                .data_out(data_out[ch]),
                .overrange_out(overrange_out[ch]),
                .data_oe(ch_oe[ch])
            );
        end
    endgenerate

    assign data_oe = ch_oe[0];

    // checks: serial gating, register storage, readback and formatting
    logic sel_s1, sel_s2;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end
        else
        begin
            sel_s1 <= interface_select;
            sel_s2 <= sel_s1;
        end
    end

    a_serial_gate: assert property (@(posedge clock) disable iff (!nrst)
        sel_s2 |=> ##1 !frame_active && !wr_stb)
        else $error("serial port active while interface_select high");

    a_frame_end: assert property (@(posedge clock) disable iff (!nrst)
        $rose(cs_n) |-> ##[1:4] !frame_active)
        else $error("frame did not close after chip select rose");

    a_write_store: assert property (@(posedge clock) disable iff (!nrst)
        wr_stb && wr_addr == `ADDR_FMT |=> q.fmt == ($past(wr_data) & `FMT_MASK))
        else $error("format register not written");

    a_regs_hold: assert property (@(posedge clock) disable iff (!nrst)
        !wr_stb |=> $stable(q))
        else $error("register changed without a write");

    a_sdo_release: assert property (@(posedge clock) disable iff (!nrst)
        !frame_active |-> !sdo_oe && !sdo_out)
        else $error("serial output driven outside a frame");

    a_soft_reset: assert property (@(posedge clock) disable iff (!nrst)
        wr_stb && wr_addr == `ADDR_RESET && wr_data[`RESET_BIT] |=> q == '0 ##1 q == '0)
        else $error("software reset did not clear registers");

    a_reset_read: assert property (@(posedge clock) disable iff (!nrst)
        rd_addr == `ADDR_RESET |-> rd_data == 8'h00)
        else $error("reset register read back nonzero");

    a_pd_unused: assert property (@(posedge clock) disable iff (!nrst)
        q.pd[7:4] == 4'h0 && !q.pd[0] && q.tim[7:4] == 4'h0)
        else $error("unused power-down or timing bits set");

    a_hiz_output: assert property (@(posedge clock) disable iff (!nrst)
        q.drv[0] |=> !data_oe)
        else $error("outputs enabled while high impedance requested");

    a_term_double: assert property (@(posedge clock) disable iff (!nrst)
        q.drv[1] |-> drive_current_qma == {base_qma[4:0], 1'b0})
        else $error("termination did not double drive current");

    a_pattern_ones: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt[2] && q.fmt[7:5] == `PAT_ONES && sample_valid && $stable(q.fmt)
        |=> data_out[0] == 14'h3FFF && overrange_out[0])
        else $error("all-ones pattern not driven");

    a_pd_write: assert property (@(posedge clock) disable iff (!nrst)
        wr_stb && wr_addr == `ADDR_PD |=> q.pd == ($past(wr_data) & `PD_MASK))
        else $error("power-down register not written");

    a_tim_write: assert property (@(posedge clock) disable iff (!nrst)
        wr_stb && wr_addr == `ADDR_TIM |=> q.tim == ($past(wr_data) & `TIM_MASK))
        else $error("timing register not written");

    a_drv_write: assert property (@(posedge clock) disable iff (!nrst)
        wr_stb && wr_addr == `ADDR_DRV |=> q.drv == ($past(wr_data) & `DRV_MASK))
        else $error("output mode register not written");

    // writes above the last register must leave the whole bank alone
    a_unmapped_write: assert property (@(posedge clock) disable iff (!nrst)
        wr_stb && wr_addr > `ADDR_FMT |=> $stable(q))
        else $error("unmapped write changed a register");

    a_wr_single: assert property (@(posedge clock) disable iff (!nrst)
        wr_stb |=> !wr_stb)
        else $error("more than one store in a frame");

    a_cs_high_idle: assert property (@(posedge clock) disable iff (!nrst)
        cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> !frame_active && !sdo_oe)
        else $error("frame open while chip select high");

    a_oe_restore: assert property (@(posedge clock) disable iff (!nrst)
        !q.drv[0] |=> data_oe)
        else $error("outputs not enabled");

    a_qma_default: assert property (@(posedge clock) disable iff (!nrst)
        q.drv[4:2] == 3'h0 && !q.drv[1] |-> drive_current_qma == 6'h0E)
        else $error("default drive current wrong");

    a_qma_min: assert property (@(posedge clock) disable iff (!nrst)
        q.drv[4:2] == 3'h7 && q.drv[1] |-> drive_current_qma == 6'h0E)
        else $error("doubled lowest drive current wrong");

    a_pattern_zero: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt[2] && q.fmt[7:5] == `PAT_ZERO && sample_valid && $stable(q.fmt)
        |=> data_out[0] == 14'h0000 && !overrange_out[0])
        else $error("all-zeros pattern not driven");

    a_pattern_alt: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt[2] && q.fmt[7:5] == `PAT_ALT && sample_valid && $stable(q.fmt)
        |=> data_out[0] == 14'h0000 && !overrange_out[0] || data_out[0] == 14'h3FFF && overrange_out[0])
        else $error("alternating pattern not driven");

    a_pattern_check: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt[2] && q.fmt[7:5] == `PAT_CHECK && sample_valid && $stable(q.fmt)
        |=> {overrange_out[0], data_out[0]} == `CHECK_EVEN || {overrange_out[0], data_out[0]} == `CHECK_ODD)
        else $error("checkerboard pattern not driven");

    // channel B keeps its own phase but must carry the same pattern
    a_pattern_chan_b: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt[2] && q.fmt[7:5] == `PAT_ONES && sample_valid && $stable(q.fmt)
        |=> data_out[1] == 14'h3FFF && overrange_out[1])
        else $error("channel B pattern not driven");

    a_raw_data: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt == 8'h00 && sample_valid && $stable(q.fmt)
        |=> data_out[0] == $past(sample[0]) && overrange_out[0] == $past(overrange_flag[0]))
        else $error("offset binary data altered");

    a_signed_msb: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt == 8'h01 && sample_valid && $stable(q.fmt) |=> data_out[0] == ($past(sample[0]) ^ 14'h2000))
        else $error("two's complement sign bit wrong");

    a_odd_invert: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt == 8'h10 && sample_valid && $stable(q.fmt) |=> data_out[0] == ($past(sample[0]) ^ `ODD_MASK))
        else $error("odd bits not inverted");

    a_scramble: assert property (@(posedge clock) disable iff (!nrst)
        q.fmt == 8'h02 && sample_valid && $stable(q.fmt)
        |=> data_out[0] == ($past(sample[0]) ^ {{13{$past(sample[0][0])}}, 1'b0}))
        else $error("scrambled data wrong");

    c_write: cover property (@(posedge clock) disable iff (!nrst) wr_stb && wr_addr == `ADDR_DRV);
    c_read: cover property (@(posedge clock) disable iff (!nrst) sdo_oe);
    c_reset: cover property (@(posedge clock) disable iff (!nrst)
        wr_stb && wr_addr == `ADDR_RESET && wr_data[`RESET_BIT]);
    c_pattern: cover property (@(posedge clock) disable iff (!nrst) q.fmt[2] && sample_valid);
    c_alternate: cover property (@(posedge clock) disable iff (!nrst)
        q.fmt[2] && q.fmt[7:5] == `PAT_ALT && sample_valid);
endmodule

// ==== adc_cfg_defines.svh ====
// offsets, field positions, reset values and timing counts of the serial configuration port
// Operation
// - Serial port works only while interface_select is held low.
// - Transfer starts on chip select low, ends on chip select high.
// - Sample input on first sixteen rising clock edges; ignore later edges.
// - Word is read/write flag, seven address bits, eight data bits, MSB first.
// - Flag low: store the eight data bits into the addressed register.
// - Flag high: shift register out, leave it unchanged, ignore input data.
// - Serial output is open drain: pull low or release only.
// - Writing one to bit 7 at address 0 clears all registers; bit self-clears.
// - Software reset register is write only and reads as zero.
// - Power-down bits: 3 sleep, 2 nap, 1 channel B off; others zero.
// - Timing bit 3 inverts output clock; bits 7 to 4 read zero.
// - Timing bits 2:1 delay output clock by 0, 1/8, 1/4, 3/8 period.
// - Timing bit 0 switches the duty-cycle stabilizer on or off.
// - Output mode bits 4:2 select drive current; 011 unused; 7 to 5 zero. Code also maps 110 to the 000 default current.
// - Output mode bit 1 enables termination and doubles the drive current.
// - Output mode bit 0 puts all digital outputs in high impedance.
// - Format bits 7:5 pick zeros, ones, alternating or checkerboard pattern.
// - Format bit 2 drives the test pattern out; bit 3 stays zero.
// - Channel A and B test patterns need not be time aligned.
// - Format bit 4 switches alternate bit polarity mode.
// - Scrambler XORs the LSB into every other data bit; code XORs it into all of bits 13:1.
// - Data is offset binary, two's complement when format bit 0 set.
// - Alternate polarity inverts the odd data bits only.
// - Test pattern overrides two's complement, scrambler and polarity modes.
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH
`define ADDR_RESET 7'h00
`define ADDR_PD 7'h01
`define ADDR_TIM 7'h02
`define ADDR_DRV 7'h03
`define ADDR_FMT 7'h04
`define RESET_BIT 7
`define REG_RESET 8'h00
`define PD_MASK 8'h0E
`define TIM_MASK 8'h0F
`define DRV_MASK 8'h1F
`define FMT_MASK 8'hF7
`define FRAME_BITS 5'h10
`define HEAD_BITS 5'h08
`define PAT_ZERO 3'h0
`define PAT_ONES 3'h1
`define PAT_ALT 3'h2
`define PAT_CHECK 3'h4
`define CHECK_EVEN 15'h5555
`define CHECK_ODD 15'h2AAA
`define ODD_MASK 14'h2AAA
`endif

// ==== adc_cfg_pkg.sv ====
// types shared by the serial configuration port modules
package adc_cfg_pkg;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_HEAD = 2'b01, ST_BODY = 2'b11, ST_DONE = 2'b10} spi_state_t;
    typedef struct packed {
        logic [1:0] cs_sy, sck_sy, sdi_sy, sel_sy;
        logic sck_d;
        spi_state_t st;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic rw;
        logic [6:0] addr;
        logic wr;
        logic sdo_oe;
    } shift_state_t;
    typedef struct packed {
        logic [14:0] word;
        logic oe;
        logic phase;
    } fmt_state_t;
    typedef struct packed {
        logic [7:0] pd, tim, drv, fmt;
    } cfg_state_t;
endpackage

// ==== adc_cfg_shifter.sv ====
// serial frame receiver and open-drain readback shifter
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_shifter
    import adc_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic interface_select,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic [7:0] rd_data,
    output logic [6:0] rd_addr,
    output logic wr_stb,
    output logic [6:0] wr_addr,
    output logic [7:0] wr_data,
    output logic frame_active,
    output logic sdo_oe
);
    shift_state_t q, n;
    logic rise, fall, active;

    always_comb
    begin
        n = q;
        n.wr = 1'b0;
        // first stage only feeds the second
        n.cs_sy = {q.cs_sy[0], cs_n};
        n.sck_sy = {q.sck_sy[0], sck};
        n.sdi_sy = {q.sdi_sy[0], sdi};
        n.sel_sy = {q.sel_sy[0], interface_select};
        n.sck_d = q.sck_sy[1];
        rise = q.sck_sy[1] & ~q.sck_d;
        fall = ~q.sck_sy[1] & q.sck_d;
        active = ~q.cs_sy[1] & ~q.sel_sy[1];
        if (!active)
        begin
            n.st = ST_IDLE;
            n.cnt = 5'h00;
            n.sdo_oe = 1'b0;
        end
        else
        begin
            if (rise && q.cnt < `FRAME_BITS)
            begin
                n.sh = {q.sh[14:0], q.sdi_sy[1]};
                n.cnt = q.cnt + 5'h01;
            end
            case (q.st)
                ST_IDLE, ST_HEAD:
                begin
                    n.st = ST_HEAD;
                    if (rise && q.cnt == `HEAD_BITS - 5'h01)
                    begin
                        n.rw = q.sh[6];
                        n.addr = {q.sh[5:0], q.sdi_sy[1]};
                        n.st = ST_BODY;
                    end
                end
                ST_BODY:
                begin
                    // readback, open drain low for zero
                    if (fall && q.rw)
                        n.sdo_oe = ~rd_data[~q.cnt[2:0]];
                    if (rise && q.cnt == `FRAME_BITS - 5'h01)
                    begin
                        n.st = ST_DONE;
                        n.wr = ~q.rw;
                    end
                end
                ST_DONE:
                begin
                    if (fall)
                        n.sdo_oe = 1'b0;
                end
                default:
                    n.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            q <= '{cs_sy: 2'h3, st: ST_IDLE, default: '0};
        else
            q <= n;
    end

    assign rd_addr = q.addr;
    assign wr_stb = q.wr;
    assign wr_addr = q.addr;
    assign wr_data = q.sh[7:0];
    assign frame_active = (q.st != ST_IDLE);
    assign sdo_oe = q.sdo_oe;
endmodule

// ==== adc_cfg_formatter.sv ====
// per-channel output data formatting and test patterns
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_formatter
    import adc_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [13:0] sample,
    input wire logic overrange_flag,
    input wire logic sample_valid,
    input wire logic [7:0] fmt_reg,
    input wire logic outputs_high_z,
    output logic [13:0] data_out,
    output logic overrange_out,
    output logic data_oe
);
    fmt_state_t q, n;
    logic [13:0] d;
    logic [14:0] w;

    always_comb
    begin
        n = q;
        d = sample;
        // two's complement flips the sign bit
        if (fmt_reg[0])
            d[13] = ~d[13];
        if (fmt_reg[1])
            d[13:1] = d[13:1] ^ {13{d[0]}};
        if (fmt_reg[4])
            d = d ^ `ODD_MASK;
        w = {overrange_flag, d};
        if (fmt_reg[2])
        begin
            case (fmt_reg[7:5])
                `PAT_ONES: w = '1;
                `PAT_ALT: w = q.phase ? 15'h0000 : 15'h7FFF;
                `PAT_CHECK: w = q.phase ? `CHECK_ODD : `CHECK_EVEN;
                default: w = 15'h0000;
            endcase
        end
        // phase runs per channel, but all channels toggle on the shared sample_valid so they stay aligned
        if (sample_valid)
        begin
            n.word = w;
            n.phase = ~q.phase;
        end
        n.oe = ~outputs_high_z;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= n;
    end

    assign data_out = q.word[13:0];
    assign overrange_out = q.word[14];
    assign data_oe = q.oe;
endmodule

// ==== adc_cfg_host.sv ====
// host model acting as serial master of the configuration port
`timescale 1ns/1ps
module adc_cfg_host
(
    input wire logic clock,
    input wire logic sdo_line,
    output logic cs_n,
    output logic sck,
    output logic sdi
);
    localparam time HALF = 24ns;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b1;
    end
    task automatic xfer(input logic [15:0] word, input int rises, output logic [7:0] rd);
        begin
            rd = 8'h00;
            @(negedge clock);
            cs_n = 1'b0;
            for (int i = 0; i < rises; i++)
            begin
                sdi = (i < 16) ? word[15 - i] : ~sdi;
                #HALF sck = 1'b1;
                #HALF;
                // sampled at the end of the high phase, where the device output has surely settled
                if (i >= 8 && i < 16)
                    rd[15 - i] = sdo_line;
                sck = 1'b0;
            end
            // no stale data once the frame is over
            sdi = ~sdi;
            #HALF cs_n = 1'b1;
            #40ns;
        end
    endtask
endmodule

// ==== adc_cfg_port_tb.sv ====
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_port_tb;
    import adc_cfg_pkg::*;
    logic clock, nrst, interface_select, cs_n, sck, sdi, sdo_out, sdo_oe, sample_valid, data_oe, sdo_line;
    logic [1:0][13:0] sample, data_out;
    logic [1:0] overrange_flag, overrange_out;
    logic sleep_en, nap_en, second_channel_powerdown, out_clock_invert, out_clock_delay_hi, out_clock_delay_lo;
    logic duty_cycle_stabilizer_en, drive_current_sel_2, drive_current_sel_1, drive_current_sel_0;
    logic internal_termination_en, pattern_enable, scramble_en, odd_bit_invert_en, signed_format_en;
    logic [5:0] drive_current_qma;
    logic [14:0] pins;
    logic [7:0] rdv, junk;
    logic [14:0] o1, o2, e1;
    logic [7:0] masks [5] = '{8'h00, `PD_MASK, `TIM_MASK, `DRV_MASK, `FMT_MASK};
    logic [5:0] cur [8] = '{6'h0E, 6'h10, 6'h12, 6'h0E, 6'h0C, 6'h0A, 6'h0E, 6'h07};
    logic [7:0] fmts [5] = '{8'h01, 8'h02, 8'h10, 8'h13, 8'h00};
    int fails = 0;
    int comparisons = 0;
    int pushes = 0;

    assign pins = {sleep_en, nap_en, second_channel_powerdown, out_clock_invert, out_clock_delay_hi,
        out_clock_delay_lo, duty_cycle_stabilizer_en, drive_current_sel_2, drive_current_sel_1,
        drive_current_sel_0, internal_termination_en, pattern_enable, scramble_en, odd_bit_invert_en,
        signed_format_en};
    assign sdo_line = sdo_oe ? sdo_out : 1'b1;

    adc_cfg_host host_u (.clock(clock), .sdo_line(sdo_line), .cs_n(cs_n), .sck(sck), .sdi(sdi));

    adc_cfg_port #(.CHANNELS(2)) dut_u (.clock(clock), .nrst(nrst), .interface_select(interface_select),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sample(sample),
        .overrange_flag(overrange_flag), .sample_valid(sample_valid), .data_out(data_out),
        .overrange_out(overrange_out), .data_oe(data_oe), .sleep_en(sleep_en), .nap_en(nap_en),
        .second_channel_powerdown(second_channel_powerdown), .out_clock_invert(out_clock_invert),
        .out_clock_delay_hi(out_clock_delay_hi), .out_clock_delay_lo(out_clock_delay_lo),
        .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en), .drive_current_sel_2(drive_current_sel_2),
        .drive_current_sel_1(drive_current_sel_1), .drive_current_sel_0(drive_current_sel_0),
        .drive_current_qma(drive_current_qma), .internal_termination_en(internal_termination_en),
        .pattern_enable(pattern_enable), .scramble_en(scramble_en), .odd_bit_invert_en(odd_bit_invert_en),
        .signed_format_en(signed_format_en));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b0, a, d}, 16, junk);
    endtask

    // data bits sent as ones so that a stray store would show
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        host_u.xfer({1'b1, a, 8'hFF}, 16, d);
    endtask

    // channel B gets the inverted sample so both paths are exercised
    task automatic push(input logic [13:0] s, output logic [14:0] o);
        @(negedge clock);
        sample = {~s, s};
        overrange_flag = 2'h1;
        sample_valid = 1'b1;
        pushes++;
        @(negedge clock);
        sample_valid = 1'b0;
        @(negedge clock);
        o = {overrange_out[0], data_out[0]};
    endtask

    function automatic logic [13:0] expect_fmt(input logic [13:0] s, input logic [7:0] f);
        logic [13:0] r;
        r = s;
        if (f[0])
            r[13] = ~r[13];
        if (f[1])
            r[13:1] = r[13:1] ^ {13{s[0]}};
        if (f[4])
            r = r ^ 14'h2AAA;
        return r;
    endfunction

    initial
    begin
        #200us;
        fails++;
        finish_test();
    end

    initial
    begin
        nrst = 1'b0;
        interface_select = 1'b0;
        sample = '0;
        overrange_flag = 2'h0;
        sample_valid = 1'b0;
        repeat (6) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        check("reset pins", {data_oe, sdo_oe, sdo_out, drive_current_qma, pins}, {3'h4, 6'h0E, 15'h0000});
        wr(7'h00, 8'h80);
        for (int a = 1; a <= 4; a++)
        begin
            rd(a[6:0], rdv);
            check("reg reset value", rdv, 8'h00);
            wr(a[6:0], 8'hFF);
            rd(a[6:0], rdv);
            check("masked readback", rdv, masks[a]);
        end
        check("all modes set", {data_oe, pins}, {1'h0, 15'h7FFF});
        rd(7'h00, rdv);
        check("reset reg read", rdv, 8'h00);
        wr(7'h00, 8'h80);
        check("cleared pins", {data_oe, drive_current_qma, pins}, {1'h1, 6'h0E, 15'h0000});
        wr(7'h01, 8'h02);
        rd(7'h01, rdv);
        rd(7'h01, rdv);
        check("read leaves reg", rdv, 8'h02);
        wr(7'h05, 8'hAA);
        rd(7'h05, rdv);
        check("unmapped read", rdv, 8'h00);
        host_u.xfer({1'b0, 7'h01, 8'h04}, 20, junk);
        host_u.xfer({1'b0, 7'h01, 8'h08}, 10, junk);
        @(negedge clock);
        interface_select = 1'b1;
        wr(7'h01, 8'h0A);
        @(negedge clock);
        interface_select = 1'b0;
        rd(7'h01, rdv);
        check("extra and partial frame", rdv, 8'h04);
        check("nap pin", pins[14:12], 3'h2);
        for (int ph = 0; ph < 4; ph++)
        begin
            wr(7'h02, {4'h0, ph[0], ph[1:0], ph != 0});
            check("timing pins", pins[11:8], {ph[0], ph[1:0], ph != 0});
        end
        for (int c = 0; c < 8; c++)
        begin
            for (int t = 0; t < 2; t++)
            begin
                wr(7'h03, {3'h0, c[2:0], t[0], 1'b0});
                check("drive current", {pins[7:4], drive_current_qma}, {c[2:0], t[0], cur[c] << t});
            end
        end
        wr(7'h03, 8'h01);
        check("outputs off", data_oe, 1'h0);
        wr(7'h03, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr(7'h04, fmts[i]);
            push(14'h1235, o1);
            check("format ch0", o1, {1'b1, expect_fmt(14'h1235, fmts[i])});
            check("format ch1", {overrange_out[1], data_out[1]}, {1'b0, expect_fmt(14'h2DCA, fmts[i])});
        end
        for (int p = 0; p < 8; p++)
        begin
            if (p == 3 || p > 4)
                continue;
            wr(7'h04, {p[2:0], 5'h17});
            // phase flips on every sample since reset and starts in the all-ones or 5555h half
            e1 = (p == 2) ? (pushes[0] ? 15'h0000 : 15'h7FFF)
                : (p == 4) ? (pushes[0] ? 15'h2AAA : 15'h5555) : ((p == 1) ? 15'h7FFF : 15'h0000);
            push(14'h1235, o1);
            push(14'h0F0F, o2);
            check("pattern first", o1, e1);
            check("pattern second", o2, (p == 2 || p == 4) ? e1 ^ 15'h7FFF : e1);
        end
        finish_test();
    end
endmodule
